// File: rtl/tap_master.sv
// Scan port master: APB registers, TCK generator, byte scan engine, pin mode
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tap_master (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             tck,
  output logic             tms,
  output logic             tdo,
  output logic             trst_n,
  input  wire logic        tdi
);

  ////////////////////////////////////////////////////////////////////////////
  logic [10:0]                 ctrl_q;
  logic [3:0]                  retime_delay_field_q;
  logic [2:0]                  pin_q;
  logic [1:0]                  irq_stat_q;
  logic [1:0]                  irq_mask_q;
  logic [7:0]                  tdo_buf_q;
  logic                        tdo_full_q;
  logic [7:0]                  tdi_buf_q;
  logic                        tdi_full_q;
  logic [2:0]                  outst_q;
  logic                        ok_q;
  logic [31:0]                 prdata_q;
  logic                        tdi_s1_q;
  logic                        tdi_s2_q;
  logic [7:0]                  div_cnt_q;
  logic                        tck_q;
  logic                        tms_q;
  logic                        tdo_q;
  tap_master_pkg::eng_state_t  state_q;
  logic [8:0]                  bytes_q;
  logic                        exit_q;
  logic [7:0]                  tx_sr_q;
  logic [3:0]                  tx_left_q;
  logic [1:0]                  pstep_q;
  logic [14:0]                 vld_sr_q;
  logic [7:0]                  rx_sr_q;
  logic [2:0]                  rx_cnt_q;
  logic [1:0]                  crst_q;

  tap_master_pkg::tck_mode_t   mode;
  logic                        discrete;
  logic                        acc;
  logic                        wr;
  logic                        rd;
  logic                        mapped;
  logic                        cond;
  logic [31:0]                 rdmux;
  logic                        tick;
  logic                        rise;
  logic                        fall;
  logic                        run;
  logic                        stall_rx;
  logic                        shift_now;
  logic                        take;
  logic                        rx_done;
  logic                        load;
  logic                        cmd_go;
  logic                        busy;

  assign mode     = tap_master_pkg::tck_mode_t'(ctrl_q[tap_master_pkg::MODE_LSB +: 2]);
  assign discrete = (mode == tap_master_pkg::MODE_DISCRETE);
  assign busy     = (state_q != tap_master_pkg::ST_IDLE);
  assign acc      = psel & penable & pready;
  assign wr       = acc & pwrite;
  assign rd       = acc & ~pwrite;
  assign cmd_go   = wr & (paddr == tap_master_pkg::CMD_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  always_comb begin
    mapped = 1'b1;
    cond   = 1'b1;
    rdmux  = 32'h0000_0000;
    unique case (paddr)
      tap_master_pkg::CTRL_OFS:   rdmux[10:0] = ctrl_q;
      tap_master_pkg::CFGB_OFS:   rdmux[3:0] = retime_delay_field_q;
      tap_master_pkg::STAT_OFS: begin
        rdmux[tap_master_pkg::ST_TDI_RDY]  = tdi_full_q;
        rdmux[tap_master_pkg::ST_TDO_FULL] = tdo_full_q;
        rdmux[tap_master_pkg::ST_BUSY]     = busy;
      end
      tap_master_pkg::CMD_OFS:    cond = ~pwrite | ~busy;
      tap_master_pkg::TDOBUF_OFS: begin
        cond = ~pwrite | (~tdo_full_q & ~((retime_delay_field_q != 4'h0) &
               (outst_q == tap_master_pkg::OUTST_MAX)));
      end
      tap_master_pkg::TDIBUF_OFS: begin
        cond        = pwrite | tdi_full_q;
        rdmux[7:0]  = tdi_buf_q;
      end
      tap_master_pkg::PIN_OFS: begin
        rdmux[2:0]                     = pin_q;
        rdmux[tap_master_pkg::PIN_TDI] = tdi_s2_q;
      end
      tap_master_pkg::IRQ_OFS:    rdmux[1:0] = irq_stat_q;
      tap_master_pkg::MASK_OFS:   rdmux[1:0] = irq_mask_q;
      default:                    mapped = 1'b0;
    endcase
  end

  // Decision is taken a cycle ahead so data and ready come from flops together;
  // it depends only on buffer, backlog and busy state, never on where TCK stands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ok_q     <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      ok_q     <= psel & ~(penable & pready) & cond;
      prdata_q <= rdmux;
    end
  end

  // Conditions only ever relax while an access waits, so ready never falls
  assign pready  = penable & ok_q;
  assign prdata  = prdata_q;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= tap_master_pkg::CTRL_RST;
      retime_delay_field_q     <= tap_master_pkg::CFGB_RST;
      irq_mask_q <= 2'h0;
    end else if (wr) begin
      if (paddr == tap_master_pkg::CTRL_OFS) ctrl_q <= pwdata[10:0];
      if (paddr == tap_master_pkg::CFGB_OFS) retime_delay_field_q <= pwdata[tap_master_pkg::RETIME_DELAY_FIELD_LSB +: 4];
      if (paddr == tap_master_pkg::MASK_OFS) irq_mask_q <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 2'h0;
    end else begin
      if (wr && paddr == tap_master_pkg::IRQ_OFS) irq_stat_q <= irq_stat_q & ~pwdata[1:0];
      if (rx_done) irq_stat_q[tap_master_pkg::IRQ_TDI] <= 1'b1;
      if (state_q == tap_master_pkg::ST_CRST && crst_q == 2'h0 && rise) begin
        irq_stat_q[tap_master_pkg::IRQ_DONE] <= 1'b1;
      end
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // TDI pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdi_s1_q <= 1'b0;
      tdi_s2_q <= 1'b0;
    end else begin
      tdi_s1_q <= tdi;
      tdi_s2_q <= tdi_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // TCK generator: half period is divisor+1 clock cycles; a lowered divisor acts at once
  assign tick = (div_cnt_q >= ctrl_q[tap_master_pkg::DIV_LSB +: 8]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 8'h00;
    end else if (tick || (load && mode == tap_master_pkg::MODE_GATED)) begin
      // Stopped gated TCK restarts its low half at a load, so TDO settles before the rise
      div_cnt_q <= 8'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // Holding TCK rather than losing a byte when the host lags on reads
  assign stall_rx = tdi_full_q & (rx_cnt_q == 3'h7);
  always_comb begin
    run = 1'b0;
    if (!discrete && !stall_rx) begin
      if (mode == tap_master_pkg::MODE_FREE) begin
        run = 1'b1;
      end else begin
        run = busy & ~(state_q == tap_master_pkg::ST_SHIFT && tx_left_q == 4'h0);
      end
    end
  end
  assign rise = tick & ~tck_q & run;
  assign fall = tick & tck_q & ~discrete;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_q <= 1'b0;
    end else if (discrete) begin
      if (acc && paddr == tap_master_pkg::PIN_OFS) tck_q <= ~pwrite;
    end else if (rise) begin
      tck_q <= 1'b1;
    end else if (fall) begin
      tck_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host buffers
  assign load = (state_q == tap_master_pkg::ST_SHIFT) & ~tck_q & (tx_left_q == 4'h0) &
                tdo_full_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo_buf_q  <= 8'h00;
      tdo_full_q <= 1'b0;
    end else if (wr && paddr == tap_master_pkg::TDOBUF_OFS) begin
      tdo_buf_q  <= pwdata[7:0];
      tdo_full_q <= 1'b1;
    end else if (load) begin
      tdo_full_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdi_buf_q  <= 8'h00;
      tdi_full_q <= 1'b0;
    end else if (rx_done) begin
      tdi_buf_q  <= {tdi_s2_q, rx_sr_q[7:1]};
      tdi_full_q <= 1'b1;
    end else if (rd && paddr == tap_master_pkg::TDIBUF_OFS) begin
      tdi_full_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outst_q <= 3'h0;
    end else begin
      unique case ({wr && paddr == tap_master_pkg::TDOBUF_OFS,
                    rd && paddr == tap_master_pkg::TDIBUF_OFS && outst_q != 3'h0})
        2'b10:   outst_q <= outst_q + 3'h1;
        2'b01:   outst_q <= outst_q - 3'h1;
        default: outst_q <= outst_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Manual pin register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= tap_master_pkg::PIN_RST;
    end else if (wr && paddr == tap_master_pkg::PIN_OFS) begin
      pin_q <= pwdata[2:0];
    end
  end

  assign tdo    = discrete ? pin_q[tap_master_pkg::PIN_TDO] : tdo_q;
  assign tms    = discrete ? pin_q[tap_master_pkg::PIN_TMS] : tms_q;
  assign trst_n = discrete ? pin_q[tap_master_pkg::PIN_TRST] : ctrl_q[tap_master_pkg::TRST_BIT];
  assign tck    = tck_q;

  ////////////////////////////////////////////////////////////////////////////
  // Scan engine
  assign shift_now = rise & (state_q == tap_master_pkg::ST_SHIFT) & (tx_left_q != 4'h0);
  // Each TDI sample belongs to the bit launched retime-delay rises earlier
  assign take      = rise & ((retime_delay_field_q == 4'h0) ? shift_now : vld_sr_q[retime_delay_field_q - 4'h1]);
  assign rx_done   = take & (rx_cnt_q == 3'h7);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vld_sr_q <= 15'h0000;
      rx_sr_q  <= 8'h00;
      rx_cnt_q <= 3'h0;
    end else begin
      if (rise) vld_sr_q <= {vld_sr_q[13:0], shift_now};
      if (take) begin
        rx_sr_q  <= {tdi_s2_q, rx_sr_q[7:1]};
        rx_cnt_q <= rx_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= tap_master_pkg::ST_IDLE;
      bytes_q   <= 9'h000;
      exit_q    <= 1'b0;
      tx_sr_q   <= 8'h00;
      tx_left_q <= 4'h0;
      pstep_q   <= 2'h0;
      crst_q    <= 2'h0;
      tms_q     <= 1'b0;
      tdo_q     <= 1'b0;
    end else begin
      unique case (state_q)
        tap_master_pkg::ST_IDLE: begin
          if (cmd_go) begin
            bytes_q   <= {1'b0, pwdata[7:0]};
            exit_q    <= pwdata[tap_master_pkg::CMD_EXIT];
            tx_left_q <= 4'h0;
            state_q   <= (pwdata[7:0] == 8'h00) ? tap_master_pkg::ST_CRST :
                         tap_master_pkg::ST_SHIFT;
            crst_q    <= tap_master_pkg::CRST_TCK;
          end
        end
        tap_master_pkg::ST_SHIFT: begin
          if (load) begin
            tx_sr_q   <= tdo_buf_q;
            tdo_q     <= tdo_buf_q[0];
            tx_left_q <= 4'h8;
            bytes_q   <= bytes_q - 9'h001;
            tms_q     <= 1'b0;
          end else if (fall && tx_left_q != 4'h0) begin
            tdo_q <= tx_sr_q[0];
            // Free TCK cannot stall for TDO data, so leave shift before running dry
            tms_q <= (tx_left_q == 4'h1) &
                     (((bytes_q == 9'h000) & exit_q) |
                      ((mode == tap_master_pkg::MODE_FREE) & (bytes_q != 9'h000) &
                       ~tdo_full_q));
          end else if (shift_now) begin
            tx_sr_q   <= {1'b0, tx_sr_q[7:1]};
            tx_left_q <= tx_left_q - 4'h1;
            if (tx_left_q == 4'h1 && bytes_q == 9'h000) begin
              state_q <= tap_master_pkg::ST_FLUSH;
            end else if (tx_left_q == 4'h1 && tms_q) begin
              state_q <= tap_master_pkg::ST_PAUSE;
              pstep_q <= 2'h0;
            end
          end
        end
        tap_master_pkg::ST_PAUSE: begin
          // Exit1 then Pause until data, then Exit2 and back to Shift
          if (fall) begin
            tms_q <= (pstep_q == 2'h0) & tdo_full_q;
            if (pstep_q == 2'h0 && tdo_full_q) pstep_q <= 2'h1;
          end else if (rise && pstep_q == 2'h1) begin
            pstep_q <= 2'h2;
          end else if (rise && pstep_q == 2'h2) begin
            state_q <= tap_master_pkg::ST_SHIFT;
          end
        end
        tap_master_pkg::ST_FLUSH: begin
          // Keep clocking until every delayed TDI bit has been caught
          if (fall) tms_q <= 1'b0;
          if (rise && vld_sr_q == 15'h0000) begin
            state_q <= tap_master_pkg::ST_CRST;
            crst_q  <= tap_master_pkg::CRST_TCK;
          end
        end
        tap_master_pkg::ST_CRST: begin
          if (rise) begin
            if (crst_q == 2'h0) begin
              state_q <= tap_master_pkg::ST_IDLE;
            end else begin
              crst_q <= crst_q - 2'h1;
            end
          end
        end
        default: state_q <= tap_master_pkg::ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: rtl/tap_master_pkg.sv
// Package: register map, fields, modes and counts of the scan port master
package tap_master_pkg;
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] CFGB_OFS    = 8'h04;
  localparam logic [7:0] STAT_OFS    = 8'h08;
  localparam logic [7:0] CMD_OFS     = 8'h0C;
  localparam logic [7:0] TDOBUF_OFS  = 8'h10;
  localparam logic [7:0] TDIBUF_OFS  = 8'h14;
  localparam logic [7:0] PIN_OFS     = 8'h18;
  localparam logic [7:0] IRQ_OFS     = 8'h1C;
  localparam logic [7:0] MASK_OFS    = 8'h20;
  // Control register: divisor [7:0], mode [9:8], trst level [10]
  localparam int         DIV_LSB     = 0;
  localparam int         MODE_LSB    = 8;
  localparam int         TRST_BIT    = 10;
  localparam logic [10:0] CTRL_RST   = 11'h401;
  // Second configuration register: retime delay [3:0]
  localparam int         RETIME_DELAY_FIELD_LSB    = 0;
  localparam logic [3:0] CFGB_RST    = 4'h0;
  // Status bits
  localparam int         ST_TDI_RDY  = 7;
  localparam int         ST_TDO_FULL = 6;
  localparam int         ST_BUSY     = 5;
  // Command: byte count [7:0], finish with exit [8]
  localparam int         CMD_EXIT    = 8;
  // Manual pin control bits
  localparam int         PIN_TDO     = 0;
  localparam int         PIN_TMS     = 1;
  localparam int         PIN_TRST    = 2;
  localparam int         PIN_TDI     = 3;
  localparam logic [2:0] PIN_RST     = 3'h4;
  // Interrupt bits
  localparam int         IRQ_TDI     = 0;
  localparam int         IRQ_DONE    = 1;
  localparam logic [2:0] OUTST_MAX   = 3'h4;
  localparam logic [1:0] CRST_TCK    = 2'h3;
  typedef enum logic [1:0] {
    MODE_GATED    = 2'h0,
    MODE_FREE     = 2'h1,
    MODE_DISCRETE = 2'h2
  } tck_mode_t;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SHIFT = 5'b00010,
    ST_PAUSE = 5'b00100,
    ST_FLUSH = 5'b01000,
    ST_CRST  = 5'b10000
  } eng_state_t;
endpackage

// File: sim/tap_master_props.sv
// Checker: assertions on the bus, pin mode and TCK pins of the scan master
`timescale 1ns/1ps
`default_nettype none
module tap_master_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        tck,
  input wire logic        tms,
  input wire logic        tdo,
  input wire logic        trst_n,
  input wire logic        tdi
);
  logic [9:0] ctl_q;
  logic [3:0] dly_q;
  logic [7:0] out_q;
  logic [8:0] half_q;
  logic       last_q;
  logic       done;
  logic       disc;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign done = psel & penable & pready;
  assign disc = ctl_q[9:8] == tap_master_pkg::MODE_DISCRETE;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of software writes, so the checks follow mode, delay and backlog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= tap_master_pkg::CTRL_RST[9:0];
      dly_q <= tap_master_pkg::CFGB_RST;
      out_q <= 8'h00;
    end else if (done && pwrite && paddr == tap_master_pkg::CTRL_OFS) begin
      ctl_q <= pwdata[9:0];
    end else if (done && pwrite && paddr == tap_master_pkg::CFGB_OFS) begin
      dly_q <= pwdata[3:0];
    end else if (done && pwrite && paddr == tap_master_pkg::TDOBUF_OFS) begin
      out_q <= out_q + 8'h01;
    end else if (done && !pwrite && paddr == tap_master_pkg::TDIBUF_OFS) begin
      out_q <= out_q - 8'h01;
    end
  end
  // Zero marks an unknown half period: a divisor write may cut one short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 1'b0;
      half_q <= 9'h000;
    end else begin
      last_q <= tck;
      if (done && pwrite && paddr == tap_master_pkg::CTRL_OFS) begin
        half_q <= 9'h000;
      end else if (tck != last_q) begin
        half_q <= 9'h001;
      end else if (half_q != 9'h000) begin
        half_q <= half_q + 9'h001;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_pin_wr;
    disc && done && pwrite && paddr == tap_master_pkg::PIN_OFS;
  endsequence
  sequence s_pin_rd;
    disc && done && !pwrite && paddr == tap_master_pkg::PIN_OFS;
  endsequence
  a_pin_write_low: assert property (
    s_pin_wr |=> !tck && {trst_n, tms, tdo} == $past(pwdata[2:0]))
    else $error("pin write did not lower TCK and set the pins");
  a_pin_read_high: assert property (
    s_pin_rd |=> tck)
    else $error("pin read did not raise TCK");
  a_other_keeps_tck: assert property (
    disc && done && paddr != tap_master_pkg::PIN_OFS && paddr != tap_master_pkg::CTRL_OFS
      |=> $stable(tck))
    else $error("TCK moved on an access to another register");
  a_tdo_backlog_cap: assert property (
    psel && penable && pwrite && paddr == tap_master_pkg::TDOBUF_OFS && dly_q != 4'h0
      && out_q >= 8'h04 |-> !pready)
    else $error("TDO write accepted beyond the backlog limit");
  a_ready_in_access: assert property (
    !penable |-> !pready)
    else $error("ready raised outside an access phase");
  a_unmapped_error: assert property (
    psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > tap_master_pkg::MASK_OFS))
    else $error("error response does not match the address map");
  a_tck_half_period: assert property (
    ctl_q[9:8] == tap_master_pkg::MODE_FREE && out_q == 8'h00 && tck != last_q
      && half_q != 9'h000 |-> half_q == {1'b0, ctl_q[7:0]} + 9'h001)
    else $error("TCK half period differs from the divisor");
  a_read_upper_zero: assert property (
    done && !pwrite |-> prdata[31:11] == 21'h0)
    else $error("unused read data bits not zero");
endmodule
bind tap_master tap_master_props i_tap_master_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .irq, .tck, .tms, .tdo, .trst_n, .tdi
);
`default_nettype wire

// File: sim/scan_target_model.sv
// Scan chain model: TDO looped back to TDI through a retime pipeline
`timescale 1ns/1ps
`default_nettype none
module scan_target_model (
  input  wire logic       tck,
  input  wire logic       tdo,
  input  wire logic       trst_n,
  input  wire logic [3:0] dly,
  output logic            tdi
);
  logic [14:0] pipe_q = 15'h0;
  // Each stage stands for one TCK rise of delay to a distant chain
  always @(posedge tck) begin
    pipe_q <= {pipe_q[13:0], tdo};
  end
  // A chain held in reset releases its output to the pull-up
  assign tdi = !trst_n ? 1'b1 : (dly == 4'h0) ? tdo : pipe_q[dly - 4'h1];
endmodule
`default_nettype wire

// File: sim/tap_master_tb.sv
// Testbench: scan port master against a looped-back scan chain model
`timescale 1ns/1ps
`default_nettype none
module tap_master_tb;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  dly     = 4'h0;
  logic [31:0] prdata, r;
  logic        pready, pslverr, irq, tck, tms, tdo, trst_n, tdi, e;
  logic [7:0]  q[$];
  int          n_errors = 0;
  int          checked  = 0;
  int          w, n;
  int          md[4] = '{0, 0, 1, 1};
  int          dl[4] = '{0, 1, 15, 4};
  int          dv[3] = '{0, 2, 5};
  always #25 pclk = ~pclk;
  tap_master i_tap_master (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .tck, .tms, .tdo, .trst_n, .tdi
  );
  scan_target_model i_scan_target_model (.tck, .tdo, .trst_n, .dly, .tdi);
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_data({31'h0, got}, {31'h0, exp});
  endtask
  task automatic hang();
    chk_bit(1'b0, 1'b1);
    give_verdict();
  endtask
  // One APB transfer; w counts access cycles, so w above 1 means wait states
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    repeat ($urandom_range(2)) @(posedge pclk);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
      if (w > 4000) hang();
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wait_stat(input int bitn, input logic v);
    n = 0;
    do begin
      apb(1'b0, tap_master_pkg::STAT_OFS, 32'h0);
      n++;
      if (n > 300) hang();
    end while (r[bitn] !== v);
  endtask
  task automatic send();
    logic [7:0] v;
    v = 8'($urandom);
    q.push_back(v);
    apb(1'b1, tap_master_pkg::TDOBUF_OFS, {24'h0, v});
  endtask
  task automatic take();
    apb(1'b0, tap_master_pkg::TDIBUF_OFS, 32'h0);
    chk_data(r, {24'h0, q.pop_front()});
  endtask
  // Counts pclk cycles up to the next TCK rise
  task automatic tck_rise();
    logic p;
    n = 0;
    do begin
      p = tck;
      @(posedge pclk);
      #1;
      n++;
      if (n > 200) hang();
    end while (!(p === 1'b0 && tck === 1'b1));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(28));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, tap_master_pkg::CTRL_OFS, 32'h0);
    chk_data(r, 32'h401);
    apb(1'b0, tap_master_pkg::CFGB_OFS, 32'h0);
    chk_data(r, 32'h0);
    apb(1'b0, tap_master_pkg::PIN_OFS, 32'h0);
    chk_data(r & 32'h7, 32'h4);
    apb(1'b0, tap_master_pkg::STAT_OFS, 32'h0);
    chk_bit(r[7], 1'b0);
    apb(1'b0, 8'h24, 32'h0);
    chk_data({r[30:0], e}, 32'h1);
    chk_data({30'h0, trst_n, tck}, 32'h2);
    $display("test reset values done");
    apb(1'b1, tap_master_pkg::MASK_OFS, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wait_stat(tap_master_pkg::ST_BUSY, 1'b0);
      repeat (16) @(posedge pclk);
      apb(1'b1, tap_master_pkg::CTRL_OFS, 32'(32'h403 | (md[i] << 8)));
      apb(1'b1, tap_master_pkg::CFGB_OFS, 32'(dl[i]));
      dly <= 4'(dl[i]);
      send();
      apb(1'b0, tap_master_pkg::STAT_OFS, 32'h0);
      chk_bit(r[6], 1'b1);
      apb(1'b1, tap_master_pkg::CMD_OFS, 32'h2);
      chk_bit(w == 1, 1'b1);
      send();
      take();
      chk_bit(w > 1, 1'b1);
      wait_stat(tap_master_pkg::ST_TDI_RDY, 1'b1);
      take();
      chk_bit(w == 1, 1'b1);
    end
    // Free TCK with the TDO buffer dry: engine must park in Pause, then resume
    wait_stat(tap_master_pkg::ST_BUSY, 1'b0);
    repeat (16) @(posedge pclk);
    apb(1'b1, tap_master_pkg::CMD_OFS, 32'h102);
    send();
    n = 0;
    repeat (200) begin
      @(posedge pclk);
      n += int'(tms);
    end
    chk_bit(n > 0 && tms == 1'b0, 1'b1);
    send();
    take();
    take();
    $display("test scan and retime done");
    chk_bit(irq, 1'b1);
    apb(1'b1, tap_master_pkg::MASK_OFS, 32'h0);
    chk_bit(irq, 1'b0);
    apb(1'b1, tap_master_pkg::MASK_OFS, 32'h1);
    chk_bit(irq, 1'b1);
    apb(1'b1, tap_master_pkg::IRQ_OFS, 32'h3);
    chk_bit(irq, 1'b0);
    $display("test interrupt done");
    wait_stat(tap_master_pkg::ST_BUSY, 1'b0);
    apb(1'b1, tap_master_pkg::CMD_OFS, 32'h0);
    apb(1'b1, tap_master_pkg::CMD_OFS, 32'h0);
    chk_bit(w > 1, 1'b1);
    $display("test command hold-off done");
    foreach (dv[k]) begin
      apb(1'b1, tap_master_pkg::CTRL_OFS, 32'(32'h500 | dv[k]));
      tck_rise();
      tck_rise();
      chk_data(32'(n), 32'(2 * (dv[k] + 1)));
    end
    $display("test divisor done");
    apb(1'b1, tap_master_pkg::CTRL_OFS, 32'h603);
    dly <= 4'h0;
    for (int v = 0; v < 8; v++) begin
      apb(1'b1, tap_master_pkg::PIN_OFS, 32'(v));
      chk_data({28'h0, tck, trst_n, tms, tdo}, 32'(v));
      // Leave time for the two-flop TDI synchroniser
      repeat (4) @(posedge pclk);
      apb(1'b0, tap_master_pkg::PIN_OFS, 32'h0);
      chk_bit(tck, 1'b1);
      chk_bit(r[3], v[2] ? v[0] : 1'b1);
      apb(1'b0, tap_master_pkg::STAT_OFS, 32'h0);
      chk_bit(tck, 1'b1);
      apb(1'b1, tap_master_pkg::CFGB_OFS, 32'h0);
      chk_bit(tck, 1'b1);
    end
    $display("test discrete mode done");
    give_verdict();
  end
endmodule
`default_nettype wire
